// File: rtl/transfer_test_exercise_sequencer.sv
// sequencer for test runs, weekly exercise and source transfer delays
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Function
// - supply-load output only at emergency with standby
// - remote input starts/stops loaded test, switch 3
// - test acts as normal loss, loaded transfers
// - test end: retransfer delay, then cooldown, stop
// - standby fails in test: retransfer at once
// - engine start delay 3 s, 1-10 s
// - transfer delay 3 s, 1-10 s
// - retransfer delay 6 min, 3-30 min
// - unloaded test skips retransfer delay
// - cooldown 5 min, 1-10 min, then stop
// - test held 6 s starts loaded test
// - test held 3-5 s starts unloaded test
// - test press during test ends it
// - weekly exercise, 20 min, 5-50 min
// - exercise held 2 s ends run early
// - exercise held 3 s: unloaded, store schedule
// - exercise held 6 s: loaded, store schedule
// - new exercise start replaces stored schedule
// - both buttons 6 s: reset, erase schedule
// - acquire-standby fault fixed at 78 s
// - loaded test blinks 1 s on, 1 off
// - loaded exercise blinks 0.5 s on, 2 off
// - engine start until retransfer and cooldown done
module transfer_test_exercise_sequencer
	import seq_pkg::*;
#(
	parameter int unsigned HALF_CYC = HALF_MS * CLK_KHZ,
	parameter int unsigned WEEK_S = WEEK_SEC
)(
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic test_btn_in,
	input wire logic exer_btn_in,
	input wire logic remote_test_in,
	input wire logic norm_avail_in,
	input wire logic standby_avail_in,
	input wire logic at_emergency_in,
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	output logic engine_start_out,
	output logic xfer_emerg_out,
	output logic supply_load_out,
	output logic fail_acquire_out,
	output logic avail_led_out,
	output logic pos_led_out
);
	if (HALF_CYC < 4 || HALF_CYC >= 2 ** 28) begin : g_chk_half
		$error("HALF_CYC out of range");
	end
	if (WEEK_S < 2 || WEEK_S >= 2 ** 20) begin : g_chk_week
		$error("WEEK_S out of range");
	end
	localparam logic [27:0] HC_LAST = 28'(HALF_CYC - 1);
	localparam logic [27:0] HC_MID = 28'(HALF_CYC / 2);
	localparam logic [19:0] WK_LAST = 20'(WEEK_S - 1);

	function automatic logic [4:0] hinc(logic [4:0] h, logic t);
		hinc = (h == HOLD_MAX) ? h : h + 5'(t);
	endfunction

	function automatic logic [15:0] pick(logic [3:0] v, logic [3:0] d,
		logic opt);
		pick = {12'h000, (opt && v >= ADJ_MIN && v <= ADJ_MAX) ? v : d};
	endfunction

	// delay length of a state in half-second units
	function automatic logic [15:0] tgt(state_t s, cfg_t c);
		case (s)
			S_START: tgt = pick(c.es_s, DEF_ES_S, c.opt_brd) * HALF_PER_S;
			S_XFER: tgt = pick(c.xf_s, DEF_XF_S, c.opt_brd) * HALF_PER_S;
			S_RETX: tgt = pick(c.rt_u, DEF_RT_U, c.opt_brd) * RT_UNIT_M
				* HALF_PER_M;
			S_COOL: tgt = pick(c.cd_m, DEF_CD_M, c.opt_brd) * HALF_PER_M;
			S_RUN: tgt = pick(c.ex_u, DEF_EX_U, c.opt_brd) * EX_UNIT_M
				* HALF_PER_M;
			default: tgt = 16'h0000;
		endcase
	endfunction

	// time base: one half-second tick and a second phase bit
	logic [27:0] hcnt, next_hcnt;
	logic half_tk, next_half_tk, sec_ph, next_sec_ph;
	logic sec_tk;
	always_comb begin
		next_hcnt = (hcnt == HC_LAST) ? 28'h0000000 : hcnt + 28'h0000001;
		next_half_tk = (hcnt == HC_LAST);
		next_sec_ph = sec_ph ^ half_tk;
	end
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hcnt <= 28'h0000000;
			half_tk <= 1'b0;
			sec_ph <= 1'b0;
		end else begin
			hcnt <= next_hcnt;
			half_tk <= next_half_tk;
			sec_ph <= next_sec_ph;
		end
	end
	assign sec_tk = half_tk & sec_ph;

	// pushbutton hold timing
	logic tb_q, eb_q, rt_q, both_seen, next_both_seen;
	logic [4:0] th, eh, bh, next_th, next_eh, next_bh;
	logic both_dn, test_rel, test_rise, exer_rel, rst_evt;
	assign both_dn = test_btn_in & exer_btn_in;
	always_comb begin
		next_th = test_btn_in ? hinc(th, half_tk) : 5'h00;
		next_eh = exer_btn_in ? hinc(eh, half_tk) : 5'h00;
		next_bh = both_dn ? hinc(bh, half_tk) : 5'h00;
		next_both_seen = both_seen;
		if (both_dn) begin
			next_both_seen = 1'b1;
		end else if (!test_btn_in && !exer_btn_in) begin
			next_both_seen = 1'b0;
		end
	end
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tb_q <= 1'b0;
			eb_q <= 1'b0;
			rt_q <= 1'b0;
			th <= 5'h00;
			eh <= 5'h00;
			bh <= 5'h00;
			both_seen <= 1'b0;
		end else begin
			tb_q <= test_btn_in;
			eb_q <= exer_btn_in;
			rt_q <= remote_test_in;
			th <= next_th;
			eh <= next_eh;
			bh <= next_bh;
			both_seen <= next_both_seen;
		end
	end
	// a two-button press never counts as a button release or a test press; it can still end an exercise run
	assign test_rel = tb_q & ~test_btn_in & ~both_seen;
	assign test_rise = test_btn_in & ~tb_q & ~exer_btn_in;
	assign exer_rel = eb_q & ~exer_btn_in & ~both_seen;
	assign rst_evt = both_dn & half_tk & (bh == RST_H - 5'h01);

	// configuration and status registers
	cfg_t cfg, next_cfg;
	logic [31:0] next_rdata;
	state_t st, next_st;
	mode_t mode, next_mode;
	logic loaded, next_loaded, eng, next_eng, xfer, next_xfer;
	logic fail, next_fail, sched_ok, next_sched_ok;
	always_comb begin
		next_cfg = cfg;
		if (wr_in && addr_in == ADDR_CFG) begin
			next_cfg = cfg_t'(wdata_in[$bits(cfg_t)-1:0]);
		end
		next_rdata = 32'h00000000;
		if (rd_in && addr_in == ADDR_CFG) begin
			next_rdata = 32'(cfg);
		end else if (rd_in && addr_in == ADDR_STAT) begin
			next_rdata = 32'({sched_ok, fail, loaded, mode, 3'(st), xfer,
				eng});
		end
	end
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cfg <= CFG_RST;
			rdata_out <= 32'h00000000;
		end else begin
			cfg <= next_cfg;
			rdata_out <= next_rdata;
		end
	end

	// weekly schedule: the counter restarts at the moment of capture
	logic [19:0] wk, next_wk;
	logic sched_set, week_due;
	assign week_due = sched_ok & sec_tk & (wk == WK_LAST);
	always_comb begin
		next_wk = wk;
		if (sched_set) begin
			next_wk = 20'h00000;
		end else if (sec_tk) begin
			next_wk = (wk == WK_LAST) ? 20'h00000 : wk + 20'h00001;
		end
		next_sched_ok = sched_ok;
		if (sched_set) begin
			next_sched_ok = 1'b1;
		end else if (rst_evt) begin
			next_sched_ok = 1'b0;
		end
	end
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wk <= 20'h00000;
			sched_ok <= 1'b0;
		end else begin
			wk <= next_wk;
			sched_ok <= next_sched_ok;
		end
	end

	// run sequencer
	logic [15:0] dcnt, next_dcnt;
	logic active, dly_done, start_req, start_ld, end_req;
	mode_t start_md;
	assign active = (st == S_START) || (st == S_XFER) || (st == S_RUN);
	assign dly_done = half_tk && (dcnt + 16'h0001 >= tgt(st, cfg));
	always_comb begin
		start_req = 1'b0;
		start_ld = 1'b0;
		start_md = M_TEST;
		sched_set = 1'b0;
		end_req = 1'b0;
		if (st == S_IDLE) begin
			if (!norm_avail_in) begin
				start_req = 1'b1;
				start_ld = 1'b1;
				start_md = M_OUTAGE;
			end else if (test_rel && th >= UNL_H) begin
				start_req = 1'b1;
				start_ld = (th >= LOAD_H);
			end else if (remote_test_in && !rt_q) begin
				start_req = 1'b1;
				start_ld = 1'b1;
			end else if (exer_rel && eh >= UNL_H) begin
				start_req = 1'b1;
				start_ld = (eh >= LOAD_H);
				start_md = M_EXER;
				sched_set = 1'b1;
			end else if (week_due) begin
				start_req = 1'b1;
				start_ld = loaded;
				start_md = M_EXER;
			end
		end else if (active && mode == M_TEST) begin
			// maintained remote switch when switch 3 is off, else momentary
			end_req = test_rise
				|| (cfg.dip3 ? (remote_test_in && !rt_q)
				: (!remote_test_in && rt_q));
		end else if (active && mode == M_EXER) begin
			end_req = exer_btn_in && half_tk && eh == END_H - 5'h01;
		end
	end
	always_comb begin
		next_st = st;
		next_mode = mode;
		next_loaded = loaded;
		next_eng = eng;
		next_xfer = xfer;
		case (st)
			S_IDLE: begin
				if (start_req) begin
					next_st = S_START;
					next_mode = start_md;
					next_loaded = start_ld;
				end
			end
			S_START: begin
				if (end_req || (mode == M_OUTAGE && norm_avail_in)) begin
					next_st = S_IDLE;
				end else if (dly_done) begin
					next_eng = 1'b1;
					next_st = loaded ? S_XFER : S_RUN;
				end
			end
			S_XFER: begin
				if (end_req || (mode == M_OUTAGE && norm_avail_in)) begin
					next_st = S_COOL;
				end else if (dly_done && standby_avail_in) begin
					next_xfer = 1'b1;
					next_st = S_RUN;
				end
			end
			S_RUN: begin
				if (end_req || (mode == M_OUTAGE && norm_avail_in)
					|| (mode == M_EXER && dly_done)) begin
					next_st = loaded ? S_RETX : S_COOL;
				end
			end
			S_RETX: begin
				if (mode == M_OUTAGE && !norm_avail_in) begin
					next_st = S_RUN;
				end else if (dly_done) begin
					next_xfer = 1'b0;
					next_st = S_COOL;
				end
			end
			S_COOL: begin
				if (mode == M_OUTAGE && !norm_avail_in) begin
					next_st = S_START;
				end else if (dly_done) begin
					next_eng = 1'b0;
					next_st = S_IDLE;
				end
			end
			default: next_st = S_IDLE;
		endcase
		// a failing standby source during a test drops the load at once
		if (xfer && !standby_avail_in && mode != M_OUTAGE) begin
			next_xfer = 1'b0;
			next_st = S_COOL;
		end
		next_dcnt = dcnt + 16'(half_tk);
		if (next_st != st || (st == S_XFER && !standby_avail_in)) begin
			next_dcnt = 16'h0000;
		end
	end
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st <= S_IDLE;
			mode <= M_TEST;
			loaded <= 1'b0;
			eng <= 1'b0;
			xfer <= 1'b0;
			dcnt <= 16'h0000;
		end else begin
			st <= next_st;
			mode <= next_mode;
			loaded <= next_loaded;
			eng <= next_eng;
			xfer <= next_xfer;
			dcnt <= next_dcnt;
		end
	end

	// acquire-standby watchdog; a new set outweighs a reset clear
	logic [7:0] acq, next_acq;
	always_comb begin
		next_acq = 8'h00;
		if (eng && !standby_avail_in) begin
			next_acq = (acq == ACQ_H) ? acq : acq + 8'(half_tk);
		end
		next_fail = fail;
		if (next_acq == ACQ_H) begin
			next_fail = 1'b1;
		end else if (standby_avail_in || rst_evt) begin
			next_fail = 1'b0;
		end
	end
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			acq <= 8'h00;
			fail <= 1'b0;
		end else begin
			acq <= next_acq;
			fail <= next_fail;
		end
	end

	// indicators and outputs
	logic [2:0] bcnt, next_bcnt;
	logic blink_on;
	leds_t leds;
	always_comb begin
		next_bcnt = bcnt;
		if (!active) begin
			next_bcnt = 3'h0;
		end else if (half_tk) begin
			next_bcnt = (bcnt == (mode == M_TEST ? TEST_PER_H : EXER_PER_H)
				- 3'h1) ? 3'h0 : bcnt + 3'h1;
		end
		blink_on = (mode == M_TEST) ? (bcnt < TEST_ON_H)
			: (bcnt < EXER_ON_H);
		leds.avail = standby_avail_in;
		leds.pos = at_emergency_in;
		if (active && mode != M_OUTAGE) begin
			leds.avail = blink_on;
			leds.pos = loaded ? blink_on : at_emergency_in;
		end else if (fail) begin
			leds.avail = (hcnt < HC_MID);
		end
	end
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bcnt <= 3'h0;
			engine_start_out <= 1'b0;
			xfer_emerg_out <= 1'b0;
			supply_load_out <= 1'b0;
			fail_acquire_out <= 1'b0;
			avail_led_out <= 1'b0;
			pos_led_out <= 1'b0;
		end else begin
			bcnt <= next_bcnt;
			engine_start_out <= next_eng;
			xfer_emerg_out <= next_xfer;
			supply_load_out <= at_emergency_in & standby_avail_in;
			fail_acquire_out <= next_fail;
			avail_led_out <= leds.avail;
			pos_led_out <= leds.pos;
		end
	end

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	sequence s_cool_end;
		st == S_COOL ##1 st == S_IDLE;
	endsequence
	a_load_output: assert property (supply_load_out |->
		$past(at_emergency_in && standby_avail_in))
		else $error("supply-load without emergency and standby");
	a_unloaded_xfer: assert property (!loaded && st != S_IDLE
		|-> !xfer_emerg_out)
		else $error("unloaded run transferred");
	a_skip_retx: assert property (st == S_RUN && !loaded
		|=> st != S_RETX)
		else $error("unloaded run used retransfer delay");
	a_standby_drop: assert property (xfer && !standby_avail_in
		&& mode != M_OUTAGE |=> !xfer_emerg_out)
		else $error("load not returned on standby failure");
	a_engine_stop: assert property ($fell(engine_start_out)
		|-> $past(st) == S_COOL && st == S_IDLE)
		else $error("engine stopped outside cooldown end");
	a_cool_idle: assert property (s_cool_end |-> !eng)
		else $error("engine still on after cooldown end");
	a_retx_order: assert property (st == S_RETX ##1 st == S_COOL
		|-> !xfer && eng)
		else $error("retransfer did not precede cooldown");
	// standby returning in the limit cycle clears the fault legally
	a_acq_fault: assert property (acq == ACQ_H && eng && !standby_avail_in
		|=> fail_acquire_out)
		else $error("acquire fault not raised at limit");
	a_sched_erase: assert property (rst_evt && !sched_set
		|=> !sched_ok)
		else $error("schedule not erased on reset hold");
	a_eng_start: assert property ($rose(eng) |-> $past(st) == S_START
		&& $past(dcnt) + 16'h0001 >= tgt(S_START, $past(cfg)))
		else $error("engine start before delay");
endmodule

// File: rtl/seq_pkg.sv
// constants and types for the transfer test and exercise sequencer
package seq_pkg;
	localparam int unsigned CLK_KHZ = 100_000;
	localparam int unsigned HALF_MS = 500;
	localparam int unsigned WEEK_SEC = 604_800;
	localparam logic [3:0] ADDR_CFG = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam logic [3:0] DEF_ES_S = 4'h3;
	localparam logic [3:0] DEF_XF_S = 4'h3;
	localparam logic [3:0] DEF_RT_U = 4'h2;
	localparam logic [3:0] DEF_CD_M = 4'h5;
	localparam logic [3:0] DEF_EX_U = 4'h4;
	localparam logic [3:0] ADJ_MIN = 4'h1;
	localparam logic [3:0] ADJ_MAX = 4'hA;
	localparam logic [15:0] HALF_PER_S = 16'h0002;
	localparam logic [15:0] HALF_PER_M = 16'h0078;
	localparam logic [15:0] RT_UNIT_M = 16'h0003;
	localparam logic [15:0] EX_UNIT_M = 16'h0005;
	localparam logic [7:0] ACQ_H = 8'h9C;
	localparam logic [4:0] HOLD_MAX = 5'h1F;
	localparam logic [4:0] LOAD_H = 5'h0C;
	localparam logic [4:0] UNL_H = 5'h06;
	localparam logic [4:0] END_H = 5'h04;
	localparam logic [4:0] RST_H = 5'h0C;
	localparam logic [2:0] TEST_PER_H = 3'h4;
	localparam logic [2:0] TEST_ON_H = 3'h2;
	localparam logic [2:0] EXER_PER_H = 3'h5;
	localparam logic [2:0] EXER_ON_H = 3'h1;
	typedef struct packed {
		logic dip3;
		logic opt_brd;
		logic [3:0] ex_u;
		logic [3:0] cd_m;
		logic [3:0] rt_u;
		logic [3:0] xf_s;
		logic [3:0] es_s;
	} cfg_t;
	localparam cfg_t CFG_RST = {1'b0, 1'b0, DEF_EX_U, DEF_CD_M, DEF_RT_U,
		DEF_XF_S, DEF_ES_S};
	typedef enum {S_IDLE, S_START, S_XFER, S_RUN, S_RETX, S_COOL} state_t;
	typedef enum logic [1:0] {M_TEST, M_EXER, M_OUTAGE} mode_t;
	typedef struct packed {
		logic avail;
		logic pos;
	} leds_t;
endpackage

// File: testbench/standby_partner.sv
// standby generator set and transfer contactor model
`timescale 1ns/1ps
module standby_partner #(
	parameter int unsigned CRANK_CYC = 5,
	parameter int unsigned MOVE_CYC = 3
)(
	input wire logic core_clk_in,
	input wire logic engine_start_in,
	input wire logic xfer_emerg_in,
	input wire logic fail_in,
	output logic standby_avail_out,
	output logic at_emergency_out
);
	int crank = 0;
	int move = 0;
	initial begin
		standby_avail_out = 1'b0;
		at_emergency_out = 1'b0;
	end
	// a commanded failure drops the source at once, cranking or not
	always @(posedge core_clk_in) begin
		crank <= (engine_start_in && !fail_in) ? crank + 1 : 0;
		standby_avail_out <= engine_start_in && !fail_in && crank >= CRANK_CYC;
		// the contactor is slow: position lags the command
		move <= (xfer_emerg_in != at_emergency_out) ? move + 1 : 0;
		if (move >= MOVE_CYC) begin
			at_emergency_out <= xfer_emerg_in;
		end
	end
endmodule

// File: testbench/transfer_test_exercise_sequencer_tb.sv
// self-checking bench for the test and exercise sequencer
`timescale 1ns/1ps
module transfer_test_exercise_sequencer_tb;
	import seq_pkg::*;
	localparam int H = 8;
	localparam int WK = 200;
	logic core_clk_in, arst_n_in, test_btn, exer_btn, remote, norm, fail;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, d;
	logic wr, rd, eng, xf, sl, fa, led_a, led_p, sb, at_em;
	logic exp_sl = 1'b0;
	logic [15:0] lfsr = 16'h0002;
	int n_mismatch = 0, check_count = 0, up = 0, now = 0, c, k, t0;
	int es_h, xf_h, rt_h, cd_h;
	cfg_t cfg;
	transfer_test_exercise_sequencer #(.HALF_CYC(H), .WEEK_S(WK)) DUT (
		.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
		.test_btn_in(test_btn), .exer_btn_in(exer_btn),
		.remote_test_in(remote), .norm_avail_in(norm),
		.standby_avail_in(sb), .at_emergency_in(at_em), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.engine_start_out(eng), .xfer_emerg_out(xf), .supply_load_out(sl),
		.fail_acquire_out(fa), .avail_led_out(led_a), .pos_led_out(led_p));
	standby_partner far_side (.core_clk_in(core_clk_in),
		.engine_start_in(eng), .xfer_emerg_in(xf), .fail_in(fail),
		.standby_avail_out(sb), .at_emergency_out(at_em));
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	function automatic logic sig(input int s);
		case (s)
			0: return eng;
			1: return xf;
			2: return sb;
			3: return led_a;
			4: return led_p;
			default: return fa;
		endcase
	endfunction
	function automatic int rnd(input int m);
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return int'(lfsr) % m;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s: %h, expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// tick phase is free running, so a delay may land up to H early
	task automatic win(input int n, input string what);
		check({31'h0, c > (n - 1) * H && c <= n * H + 4}, 32'h1, what);
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge core_clk_in);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge core_clk_in);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a);
		@(posedge core_clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk_in);
		rd <= 1'b0;
		@(negedge core_clk_in);
		d = rdata;
	endtask
	task automatic stat(input logic [6:0] e, input logic [6:0] m);
		reg_rd(ADDR_STAT);
		check({25'h0, {d[9], d[7:2]} & m}, {25'h0, e & m}, "status");
	endtask
	task automatic press(input int b, input int n);
		@(posedge core_clk_in);
		test_btn <= (b != 1);
		exer_btn <= (b != 0);
		repeat (n) @(posedge core_clk_in);
		test_btn <= 1'b0;
		exer_btn <= 1'b0;
	endtask
	task automatic wait_lvl(input int s, input logic v, input int lim);
		c = 0;
		while (sig(s) !== v) begin
			@(posedge core_clk_in);
			c++;
			if (c > lim) begin
				n_mismatch++;
				$display("[FAIL] %0t wait on output %0d ran out", $time, s);
				end_of_test();
			end
		end
	endtask
	task automatic count(input int s, input int n, input int e);
		k = 0;
		repeat (n) begin
			@(posedge core_clk_in);
			k += int'(sig(s));
		end
		check(32'(k), 32'(e), "lamp on time");
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	always @(posedge core_clk_in) begin
		now <= now + 1;
		up <= arst_n_in ? up + 1 : 0;
		if (up > 1) begin
			check({31'h0, sl}, {31'h0, exp_sl}, "supply load");
		end
		exp_sl <= at_em & sb;
	end
	initial begin
		arst_n_in = 1'b0;
		{test_btn, exer_btn, remote, fail, wr, rd} = 6'h00;
		norm = 1'b1;
		addr = 4'h0;
		wdata = 32'h0;
		repeat (10) @(posedge core_clk_in);
		arst_n_in <= 1'b1;
		reg_wr(4'h8, 32'hFFFF_FFFF);
		reg_rd(ADDR_CFG);
		check(d, 32'(CFG_RST), "cfg reset");
		reg_rd(4'h8);
		check(d, 32'h0, "unmapped read");
		cfg = {1'b0, 1'b1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h1};
		reg_wr(ADDR_CFG, 32'(cfg));
		reg_rd(ADDR_CFG);
		check(d, 32'(cfg), "cfg readback");
		es_h = 1 * int'(HALF_PER_S);
		xf_h = 2 * int'(HALF_PER_S);
		rt_h = 1 * int'(RT_UNIT_M) * int'(HALF_PER_M);
		cd_h = 1 * int'(HALF_PER_M);
		done("registers");
		press(0, (13 + rnd(3)) * H);
		wait_lvl(0, 1'b1, es_h * H + 4);
		win(es_h, "engine delay");
		wait_lvl(2, 1'b1, 40);
		wait_lvl(1, 1'b1, xf_h * H + 4);
		win(xf_h, "transfer delay");
		stat(7'h23, 7'h7F);
		count(3, 8 * H, 4 * H);
		count(4, 8 * H, 4 * H);
		press(0, 2);
		wait_lvl(1, 1'b0, rt_h * H + 4);
		win(rt_h, "retransfer delay");
		wait_lvl(0, 1'b0, cd_h * H + 4);
		win(cd_h, "cooldown");
		done("loaded test");
		press(0, (7 + rnd(4)) * H);
		wait_lvl(0, 1'b1, es_h * H + 4);
		win(es_h, "engine delay");
		count(3, 8 * H, 4 * H);
		check({31'h0, xf}, 32'h0, "no transfer");
		stat(7'h03, 7'h7F);
		press(0, 2);
		wait_lvl(0, 1'b0, cd_h * H + 8);
		win(cd_h, "unloaded stop");
		done("unloaded test");
		@(posedge core_clk_in);
		fail <= 1'b1;
		remote <= 1'b1;
		wait_lvl(0, 1'b1, es_h * H + 8);
		wait_lvl(5, 1'b1, int'(ACQ_H) * H + 8);
		win(int'(ACQ_H), "acquire fault");
		fail <= 1'b0;
		wait_lvl(5, 1'b0, 20);
		wait_lvl(1, 1'b1, xf_h * H + 20);
		fail <= 1'b1;
		wait_lvl(1, 1'b0, 4);
		check({31'h0, c <= 4}, 32'h1, "drop on loss");
		wait_lvl(0, 1'b0, cd_h * H + 8);
		win(cd_h, "cooldown after loss");
		remote <= 1'b0;
		fail <= 1'b0;
		cfg.dip3 = 1'b1;
		reg_wr(ADDR_CFG, 32'(cfg));
		remote <= 1'b1;
		@(posedge core_clk_in);
		remote <= 1'b0;
		wait_lvl(1, 1'b1, (es_h + xf_h + 2) * H);
		remote <= 1'b1;
		@(posedge core_clk_in);
		remote <= 1'b0;
		wait_lvl(1, 1'b0, rt_h * H + 8);
		win(rt_h, "remote toggle end");
		wait_lvl(0, 1'b0, cd_h * H + 8);
		done("remote test");
		press(1, (7 + rnd(4)) * H);
		t0 = now;
		wait_lvl(0, 1'b1, es_h * H + 8);
		stat(7'h4B, 7'h7F);
		count(3, 10 * H, 2 * H);
		check({31'h0, xf}, 32'h0, "no transfer");
		press(1, 5 * H);
		wait_lvl(0, 1'b0, cd_h * H + 8 * H);
		stat(7'h40, 7'h40);
		wait_lvl(0, 1'b1, 2 * WK * H + 4 * es_h * H);
		c = now - t0;
		check({31'h0, c > (2 * WK + es_h - 3) * H &&
			c <= (2 * WK + es_h + 1) * H}, 32'h1, "weekly start");
		wait_lvl(0, 1'b0, (600 + cd_h + 10) * H);
		check({31'h0, c > (600 + cd_h - 3) * H && c <= (600 + cd_h + 1) * H},
			32'h1, "run length");
		done("unloaded exercise");
		press(2, 14 * H);
		stat(7'h00, 7'h47);
		check({31'h0, eng}, 32'h0, "no start");
		press(1, (13 + rnd(3)) * H);
		wait_lvl(1, 1'b1, (es_h + xf_h + 4) * H);
		stat(7'h6B, 7'h7F);
		count(3, 10 * H, 2 * H);
		count(4, 10 * H, 2 * H);
		press(1, 5 * H);
		wait_lvl(0, 1'b0, (rt_h + cd_h + 20) * H);
		done("loaded exercise");
		@(posedge core_clk_in);
		norm <= 1'b0;
		wait_lvl(1, 1'b1, (es_h + xf_h + 4) * H);
		stat(7'h33, 7'h3F);
		norm <= 1'b1;
		wait_lvl(1, 1'b0, rt_h * H + 8);
		win(rt_h, "outage retransfer");
		wait_lvl(0, 1'b0, cd_h * H + 8);
		win(cd_h, "outage cooldown");
		done("outage");
		end_of_test();
	end
endmodule
